// ===== core/cjd_top.sv
`include "cjd_consts.svh"
`default_nettype none
module cjd_top
  import cjd_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic [`CJD_KEYS-1:0]     jump_key,
  input  wire logic                     restart,
  input  wire logic                     mem_ready,
  input  wire logic [`CJD_ZREG_W-1:0]   mem_rdata,
  input  wire logic                     xfer_req,
  input  wire logic [1:0]               xfer_op,
  input  wire logic [`CJD_WORD_W-1:0]   xfer_mask,
  input  wire logic [`CJD_WORD_W-1:0]   acc_in,
  output logic                          mem_read,
  output logic                          mem_write,
  output logic                          mem_clear,
  output logic [`CJD_SADDR_W-1:0]       mem_addr,
  output logic [`CJD_ZREG_W-1:0]        mem_wdata,
  output logic [`CJD_ADDR_W-1:0]        prog_addr,
  output logic [`CJD_WORD_W-1:0]        instr,
  output logic [`CJD_WORD_W-1:0]        aux_reg,
  output logic                          aux_neg,
  output logic                          halted,
  output logic                          unimpl
);
  // Console and storage inputs are asynchronous to this clock
  logic [`CJD_KEYS-1:0]   key_s1;
  logic [`CJD_KEYS-1:0]   key_s2;
  logic                   rst_s1;
  logic                   rst_s2;
  logic                   rst_d;
  logic                   rdy_s1;
  logic                   rdy_s2;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      key_s1 <= '0;
      key_s2 <= '0;
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
      rst_d  <= 1'b0;
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
    end else begin
      key_s1 <= jump_key;
      key_s2 <= key_s1;
      rst_s1 <= restart;
      rst_s2 <= rst_s1;
      rst_d  <= rst_s2;
      rdy_s1 <= mem_ready;
      rdy_s2 <= rdy_s1;
    end
  end
  logic restart_pulse;
  assign restart_pulse = rst_s2 & ~rst_d;

  cjd_state_t                 state;
  cjd_state_t                 next_state;
  logic [`CJD_ADDR_W-1:0]     next_prog_addr;
  logic [`CJD_WORD_W-1:0]     next_instr;
  logic [`CJD_ZREG_W-1:0]     zreg;
  logic [`CJD_ZREG_W-1:0]     next_zreg;
  logic [`CJD_SADDR_W-1:0]    next_mem_addr;
  logic                       next_mem_read;
  logic                       next_mem_write;
  logic                       next_mem_clear;
  logic                       next_halted;
  logic                       next_unimpl;
  logic [`CJD_ADDR_W-1:0]     ret_addr;
  logic [`CJD_ADDR_W-1:0]     p_plus1;
  logic [`CJD_ADDR_W-1:0]     m_plus1;
  logic [`CJD_ADDR_W-1:0]     m_field;
  logic [`CJD_OP_W-1:0]       opcode;
  logic [2:0]                 sub;
  logic                       key_hit;
  logic                       armed;
  logic                       next_armed;

  cjd_ones_add #(.W(`CJD_ADDR_W)) u_pinc (
    .a   (prog_addr),
    .b   (`CJD_P_ONE),
    .sum (p_plus1)
  );
  cjd_ones_add #(.W(`CJD_ADDR_W)) u_minc (
    .a   (m_field),
    .b   (`CJD_P_ONE),
    .sum (m_plus1)
  );

  always_comb begin
    opcode  = instr[`CJD_OP_MSB:`CJD_OP_LSB];
    sub     = instr[`CJD_SUB_MSB:`CJD_SUB_LSB];
    m_field = instr[`CJD_ADDR_W-1:0];
    key_hit = 1'b0;
    if (sub != `CJD_SUB_HALT && sub != `CJD_SUB_RTJ) begin
      key_hit = key_s2[sub - 3'h1];
    end
  end

  always_comb begin
    next_state     = state;
    next_prog_addr = prog_addr;
    next_instr     = instr;
    next_zreg      = zreg;
    next_mem_addr  = mem_addr;
    next_mem_read  = 1'b0;
    next_mem_write = 1'b0;
    next_mem_clear = 1'b0;
    next_halted    = halted;
    next_unimpl    = unimpl;
    next_armed     = 1'b0;
    case (state)
      CJD_FETCH: begin
        next_mem_addr = prog_addr[`CJD_SADDR_W-1:0];
        next_mem_read = 1'b1;
        next_state    = CJD_FWAIT;
      end
      CJD_FWAIT: begin
        // Synced ready trails storage by two edges; the last access's ready
        // must be seen low first, or stale data would be taken twice
        next_mem_read = 1'b1;
        next_armed    = armed | ~rdy_s2;
        if (armed && rdy_s2) begin
          next_mem_read = 1'b0;
          next_armed    = 1'b0;
          next_zreg     = mem_rdata;
          next_instr    = mem_rdata[`CJD_WORD_W-1:0];
          next_state    = CJD_DECODE;
        end
      end
      CJD_DECODE: begin
        next_state = CJD_FETCH;
        if (opcode != `CJD_GROUP0) begin
          // Other groups belong to other decoders; flag and step on
          next_unimpl    = 1'b1;
          next_prog_addr = p_plus1;
        end else begin
          case (sub)
            `CJD_SUB_HALT: begin
              next_halted    = 1'b1;
              next_prog_addr = m_field;
              next_state     = CJD_HALTED;
            end
            `CJD_SUB_RTJ: begin
              next_mem_addr = m_field[`CJD_SADDR_W-1:0];
              next_mem_read = 1'b1;
              next_state    = CJD_RDM;
            end
            default: begin
              if (key_hit) begin
                next_prog_addr = m_field;
              end else begin
                next_prog_addr = p_plus1;
              end
            end
          endcase
        end
      end
      CJD_HALTED: begin
        if (restart_pulse) begin
          next_halted = 1'b0;
          next_state  = CJD_FETCH;
        end
      end
      CJD_RDM: begin
        // Read-modify-write keeps the upper 13 bits of m intact
        next_mem_read = 1'b1;
        next_armed    = armed | ~rdy_s2;
        if (armed && rdy_s2) begin
          next_mem_read = 1'b0;
          next_armed    = 1'b0;
          next_zreg     = mem_rdata;
          next_zreg[`CJD_ADDR_W-1:0] = ret_addr;
          next_state    = CJD_RWAIT;
        end
      end
      CJD_RWAIT: begin
        next_mem_clear = 1'b1;
        next_state     = CJD_WRM;
      end
      CJD_WRM: begin
        next_mem_write = 1'b1;
        next_armed     = armed | ~rdy_s2;
        if (armed && rdy_s2 && mem_write) begin
          next_mem_write = 1'b0;
          next_armed     = 1'b0;
          next_prog_addr = m_plus1;
          next_state     = CJD_FETCH;
        end
      end
      default: begin
        next_state = CJD_FETCH;
      end
    endcase
  end

  always_comb begin
    ret_addr = p_plus1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state     <= CJD_FETCH;
      prog_addr <= `CJD_P_RESET;
      instr     <= '0;
      zreg      <= '0;
      mem_addr  <= '0;
      mem_read  <= 1'b0;
      mem_write <= 1'b0;
      mem_clear <= 1'b0;
      halted    <= 1'b0;
      unimpl    <= 1'b0;
      armed     <= 1'b0;
    end else begin
      state     <= next_state;
      prog_addr <= next_prog_addr;
      instr     <= next_instr;
      zreg      <= next_zreg;
      mem_addr  <= next_mem_addr;
      mem_read  <= next_mem_read;
      mem_write <= next_mem_write;
      mem_clear <= next_mem_clear;
      halted    <= next_halted;
      unimpl    <= next_unimpl;
      armed     <= next_armed;
    end
  end

  always_comb begin
    mem_wdata = zreg;
  end

  // Auxiliary register; operand comes from the same-clock accumulator side
  logic [`CJD_WORD_W-1:0] next_aux;
  logic [`CJD_WORD_W-1:0] ext15;
  always_comb begin
    ext15 = {{(`CJD_WORD_W-`CJD_ADDR_W){acc_in[`CJD_ADDR_W-1]}},
             acc_in[`CJD_ADDR_W-1:0]};
    next_aux = aux_reg;
    if (xfer_req) begin
      case (cjd_xop_t'(xfer_op))
        CJD_X_NONE:   next_aux = acc_in;
        CJD_X_NEGATE: next_aux = ~acc_in;
        CJD_X_TOGGLE: next_aux = aux_reg ^ xfer_mask;
        CJD_X_SEXT:   next_aux = ext15;
        default:      next_aux = aux_reg;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      aux_reg <= '0;
      aux_neg <= 1'b0;
    end else begin
      aux_reg <= next_aux;
      aux_neg <= next_aux[`CJD_WORD_W-1];
    end
  end
endmodule
`default_nettype wire

// ===== inc/cjd_consts.svh
// Contract
// - Operation taken from the six-bit operation code field of each word.
// - Program counter counts one's complement, modulus two to fifteenth minus one.
// - Top stage of a signed register is the sign, one negative.
// - Negation inverts every bit of the positive value.
// - Sign extension copies the sign bit into every higher stage.
// - A 24-bit auxiliary arithmetic register assists the accumulator.
// - A 28-bit data register captures reads and holds writes, with parity. The four parity bits are carried through but never generated or checked.
// - A 13-bit address register presents the word being accessed.
// - Data words are 24 bits; a location holds instruction or data.
// - A store clears the target location, then copies the register into it.
// - Replace writes the result back to the operand's own location.
// - Register transfer copies source to destination, leaving the source unchanged.
// - Toggle inverts selected bits and leaves the others alone.
// - Operation 00.0 halts; restart reads next instruction from the address field.
// - Operations 00.1 to 00.6 jump to m when the numbered key is set.
// - Operation 00.7 writes P plus one into m's address, continues at m plus one.
`ifndef CJD_CONSTS_SVH
`define CJD_CONSTS_SVH
`define CJD_WORD_W     24
`define CJD_OP_W       6
`define CJD_OP_MSB     23
`define CJD_OP_LSB     18
`define CJD_SUB_MSB    17
`define CJD_SUB_LSB    15
`define CJD_ADDR_W     15
`define CJD_SADDR_W    13
`define CJD_ZREG_W     28
`define CJD_PAR_W      4
`define CJD_KEYS       6
`define CJD_GROUP0     6'h00
`define CJD_SUB_HALT   3'h0
`define CJD_SUB_RTJ    3'h7
`define CJD_P_RESET    15'h0000
`define CJD_P_ONE      15'h0001
`define CJD_P_MAX      15'h7fff
`endif

// ===== inc/cjd_pkg.sv
`default_nettype none
package cjd_pkg;
  typedef enum logic [6:0] {
    CJD_FETCH   = 7'h01,
    CJD_FWAIT   = 7'h02,
    CJD_DECODE  = 7'h04,
    CJD_HALTED  = 7'h08,
    CJD_RDM     = 7'h10,
    CJD_RWAIT   = 7'h20,
    CJD_WRM     = 7'h40
  } cjd_state_t;
  typedef enum logic [1:0] {
    CJD_X_NONE   = 2'h0,
    CJD_X_NEGATE = 2'h1,
    CJD_X_TOGGLE = 2'h2,
    CJD_X_SEXT   = 2'h3
  } cjd_xop_t;
endpackage
`default_nettype wire

// ===== core/cjd_ones_add.sv
`include "cjd_consts.svh"
`default_nettype none
module cjd_ones_add #(
  parameter int W = 15
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  output var  logic [W-1:0] sum
);
  logic [W:0]   raw;
  logic [W-1:0] wrapped;
  always_comb begin
    // End-around carry; all-ones is minus zero and folds to zero
    raw = {1'b0, a} + {1'b0, b};
    wrapped = raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};
    sum = (&wrapped) ? '0 : wrapped;
  end
endmodule
`default_nettype wire

// ===== verification/cjd_top_asserts.sv
`include "cjd_consts.svh"
`default_nettype none
module cjd_top_asserts (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        mem_ready,
  input wire logic        xfer_req,
  input wire logic [1:0]  xfer_op,
  input wire logic [23:0] xfer_mask,
  input wire logic [23:0] acc_in,
  input wire logic        mem_read,
  input wire logic        mem_write,
  input wire logic        mem_clear,
  input wire logic [12:0] mem_addr,
  input wire logic [27:0] mem_wdata,
  input wire logic [14:0] prog_addr,
  input wire logic [23:0] aux_reg,
  input wire logic        aux_neg,
  input wire logic        halted,
  input wire logic        unimpl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_aux_copy: assert property (xfer_req && xfer_op == 2'h0
    |=> aux_reg == $past(acc_in)) else $error("aux copy wrong");
  chk_aux_negate: assert property (xfer_req && xfer_op == 2'h1
    |=> aux_reg == ~$past(acc_in)) else $error("aux negate wrong");
  chk_aux_toggle: assert property (xfer_req && xfer_op == 2'h2
    |=> aux_reg == ($past(aux_reg) ^ $past(xfer_mask)))
    else $error("aux toggle wrong");
  chk_aux_sext: assert property (xfer_req && xfer_op == 2'h3
    |=> aux_reg == {{9{$past(acc_in[14])}}, $past(acc_in[14:0])})
    else $error("aux extend wrong");
  chk_aux_sign: assert property (aux_neg == aux_reg[23])
    else $error("aux sign wrong");
  chk_p_modulus: assert property (prog_addr != 15'h7fff)
    else $error("minus zero in counter");
  chk_clear_write: assert property (mem_clear
    |=> !mem_clear ##[0:2] mem_write) else $error("clear not then write");
  chk_read_hold: assert property (mem_read && !mem_ready
    |=> mem_read && $stable(mem_addr)) else $error("read dropped early");
  chk_write_hold: assert property (mem_write && !mem_ready
    |=> mem_write && $stable(mem_wdata)) else $error("write dropped early");
  chk_halt_quiet: assert property ($rose(halted)
    |-> !mem_read && !mem_write) else $error("access while halting");
  chk_unimpl_sticky: assert property (unimpl |=> unimpl)
    else $error("unimpl cleared");
  cover property ($rose(halted));
  cover property (mem_clear);
  cover property (xfer_req && xfer_op == 2'h2);
endmodule
bind cjd_top cjd_top_asserts cjd_top_asserts_i (.clk(clk), .rstn(rstn),
  .mem_ready(mem_ready), .xfer_req(xfer_req), .xfer_op(xfer_op),
  .xfer_mask(xfer_mask), .acc_in(acc_in), .mem_read(mem_read),
  .mem_write(mem_write), .mem_clear(mem_clear), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .prog_addr(prog_addr), .aux_reg(aux_reg),
  .aux_neg(aux_neg), .halted(halted), .unimpl(unimpl));
`default_nettype wire

// ===== verification/cjd_storage_model.sv
`default_nettype none
module cjd_storage_model (
  input  wire logic        clk,
  input  wire logic [1:0]  dly,
  input  wire logic        mem_read,
  input  wire logic        mem_write,
  input  wire logic        mem_clear,
  input  wire logic [12:0] mem_addr,
  input  wire logic [27:0] mem_wdata,
  output var  logic        mem_ready,
  output var  logic [27:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [27:0] mem [0:8191];
  logic [1:0]  cnt;
  initial begin
    mem_ready = 1'b0;
    mem_rdata = 28'h0;
    cnt = 2'h0;
  end
  always @(posedge clk) begin
    if (mem_clear) mem[mem_addr] <= 28'h0;
    if (!(mem_read || mem_write)) begin
      mem_ready <= 1'b0;
      // Stale data flips so a late sample never looks valid
      mem_rdata <= ~mem_rdata;
      cnt <= 2'h0;
    end else if (cnt < dly) begin
      cnt <= cnt + 2'h1;
    end else if (!mem_ready) begin
      mem_ready <= 1'b1;
      if (mem_write) mem[mem_addr] <= mem_wdata;
      else mem_rdata <= mem[mem_addr];
    end
  end
endmodule
`default_nettype wire

// ===== verification/control_jump_decoder_test.sv
`default_nettype none
module control_jump_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, restart, xfer_req, mem_ready, mem_read, mem_write;
  logic mem_clear, aux_neg, halted, unimpl;
  logic [5:0] jump_key;
  logic [1:0] xfer_op, dly;
  logic [12:0] mem_addr;
  logic [14:0] prog_addr, p, m, e;
  logic [23:0] xfer_mask, acc_in, instr, aux_reg, ea;
  logic [27:0] mem_rdata, mem_wdata, old;
  int seed = 32'h5ff9;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  cjd_top cjd_top_i (.clk(clk), .rstn(rstn), .jump_key(jump_key),
    .restart(restart), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .xfer_req(xfer_req), .xfer_op(xfer_op), .xfer_mask(xfer_mask),
    .acc_in(acc_in), .mem_read(mem_read), .mem_write(mem_write),
    .mem_clear(mem_clear), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .prog_addr(prog_addr), .instr(instr), .aux_reg(aux_reg),
    .aux_neg(aux_neg), .halted(halted), .unimpl(unimpl));
  cjd_storage_model cjd_storage_model_i (.clk(clk), .dly(dly),
    .mem_read(mem_read), .mem_write(mem_write), .mem_clear(mem_clear),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata));
  function automatic logic [14:0] inc(input logic [14:0] a);
    return (a == 15'h7ffe) ? 15'h0 : a + 15'h1;
  endfunction
  function automatic logic [23:0] fx(input logic [1:0] o,
                                     input logic [23:0] a, x, k);
    case (o)
      2'h0: fx = a;
      2'h1: fx = ~a;
      2'h2: fx = k ^ x;
      default: fx = {{9{a[14]}}, a[14:0]};
    endcase
  endfunction
  task automatic finish_test;
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [27:0] g, input logic [27:0] x);
    samples_checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #5;
  endtask
  // Counts read starts, operand reads included; bounded so a stuck bus cannot hang
  task automatic wf(input int n);
    int k;
    for (int j = 0; j < n; j++) begin
      k = 0;
      while (mem_read !== 1'b0 && k < 99) begin tick(); k++; end
      while (mem_read !== 1'b1 && k < 199) begin tick(); k++; end
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    int i, k, sub;
    {rstn, restart, xfer_req, jump_key, xfer_op, dly} = '0;
    {xfer_mask, acc_in} = '0;
    cjd_storage_model_i.mem[0] = {4'h0, 6'h00, 3'h1, 15'h0};
    repeat (4) @(posedge clk);
    #5 rstn = 1'b1;
    cmp(prog_addr, 28'h0);
    cmp(aux_reg, 28'h0);
    wf(2);
    cmp(prog_addr, 28'h1);
    p = 15'h1;
    for (i = 0; i < 20; i++) begin
      sub = i % 8;
      m = $random(seed) & 15'h3fff;
      jump_key = $random(seed);
      dly = $random(seed);
      if (i == 2) begin m = 15'h7ffe; jump_key = 6'h3f; end
      if (i == 3) jump_key = 6'h00;
      // Keep the operand word apart from the instruction word
      if (m[12:0] == p[12:0]) m = m ^ 15'h0001;
      old = $random(seed);
      cjd_storage_model_i.mem[m[12:0]] = old;
      cjd_storage_model_i.mem[p[12:0]] = {4'h0, 6'h00, sub[2:0], m};
      case (sub)
        0: e = m;
        7: e = inc(m);
        default: e = jump_key[sub-1] ? m : inc(p);
      endcase
      if (sub == 0) begin
        for (k = 0; k < 60 && halted !== 1'b1; k++) tick();
        cmp(halted, 28'h1);
        restart = 1'b1;
        repeat (4) tick();
        restart = 1'b0;
        // The fetch at m starts right after restart; wait for it only
        for (k = 0; k < 20 && mem_read !== 1'b1; k++) tick();
        cmp(halted, 28'h0);
      end else begin
        wf(sub == 7 ? 2 : 1);
      end
      cmp(prog_addr, e);
      cmp(mem_addr, e[12:0]);
      cmp(instr, {6'h00, sub[2:0], m});
      if (sub == 7) cmp(mem_wdata, {old[27:15], inc(p)});
      if (sub == 7) cmp(cjd_storage_model_i.mem[m[12:0]],
                        {old[27:15], inc(p)});
      p = e;
    end
    cjd_storage_model_i.mem[p[12:0]] = {4'h0, 6'h2a, 18'h0};
    cjd_storage_model_i.mem[inc(p) & 15'h1fff] = 28'h0;
    wf(1);
    cmp(unimpl, 28'h1);
    cmp(prog_addr, inc(p));
    ea = aux_reg;
    for (i = 0; i < 12; i++) begin
      xfer_req = 1'b1;
      xfer_op = i;
      acc_in = (i == 1) ? 24'h0 : (i == 3) ? 24'h004000 : $random(seed);
      xfer_mask = $random(seed);
      ea = fx(xfer_op, acc_in, xfer_mask, ea);
      tick();
      xfer_req = 1'b0;
      cmp(aux_reg, ea);
      cmp(aux_neg, ea[23]);
      tick();
    end
    finish_test();
  end
endmodule
`default_nettype wire
